/* File: core/besc_phase_gen.sv */
`timescale 1ns/100ps
module besc_phase_gen
    import besc_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic slow_clock_in,
    input wire logic fast_clock_in,
    input wire logic phase_clock_source_select,
    besc_phase_if.gen ph
);
    typedef struct packed {
        logic phase;
        logic rise;
        logic fall;
    } besc_gen_t;

    besc_gen_t gen_reg;
    besc_gen_t gen_next;
    logic src;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        gen_next = gen_reg;
        src = (phase_clock_source_select == SRC_FAST) ? fast_clock_in : slow_clock_in;
        if (clock_enable) begin
            // Phase runs free of the bus enable level
            gen_next.phase = src;
            gen_next.rise = src && !gen_reg.phase;
            gen_next.fall = !src && gen_reg.phase;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            gen_reg <= '{phase: PHASE_RESET, rise: 1'b0, fall: 1'b0};
        end else begin
            gen_reg <= gen_next;
        end
    end

    assign ph.phase = gen_reg.phase;
    assign ph.rise = gen_reg.rise;
    assign ph.fall = gen_reg.fall;

    ////////////////////////////////////////////////////////////////////////////////
    a_phase_source: assert property (@(posedge clock) disable iff (reset)
        clock_enable ##1 clock_enable |-> gen_reg.phase ==
            $past(src))
        else $error("phase-two does not follow selected source");

    a_fall_marks: assert property (@(posedge clock) disable iff (reset)
        gen_reg.fall |-> !gen_reg.phase && !gen_reg.rise)
        else $error("fall marker with phase high");
endmodule : besc_phase_gen

/* File: core/besc_top.sv */
`timescale 1ns/100ps
module besc_top
    import besc_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic slow_clock_in,
    input wire logic fast_clock_in,
    input wire logic phase_clock_source_select,
    input wire logic bus_enable_in,
    input wire logic [ADDR_W-1:0] core_addr,
    input wire logic [DATA_W-1:0] core_wdata,
    input wire logic core_write,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic write_strobe_n_in,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic phase_two_clock_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic write_strobe_n,
    output logic write_strobe_n_oe,
    output logic core_ready,
    output logic [DATA_W-1:0] core_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    output logic mem_we,
    output logic stalled,
    output logic released
);
    initial begin
        if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32) begin
            $error("besc_top: unsupported bus width");
        end
    end

    typedef struct packed {
        besc_mode_t mode;
        logic cycle_done;
        logic cycle_write;
        logic [ADDR_W-1:0] addr_out;
        logic addr_oe;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
        logic wstrobe_n;
        logic wstrobe_oe;
        logic ready;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic mem_we;
        logic stall_flag;
        logic release_flag;
    } besc_state_t;

    besc_state_t st_reg;
    besc_state_t st_next;

    besc_phase_if ph_if ();

    besc_phase_gen u_phase (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .slow_clock_in(slow_clock_in),
        .fast_clock_in(fast_clock_in),
        .phase_clock_source_select(phase_clock_source_select),
        .ph(ph_if.gen)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.ready = 1'b0;
        st_next.mem_we = 1'b0;
        if (clock_enable) begin
            // Meaning of bus enable depends on the phase it is seen in
            if (!ph_if.phase) begin
                if (!bus_enable_in) begin
                    st_next.mode = BESC_RELEASE;
                end else if (st_reg.mode == BESC_RELEASE) begin
                    st_next.mode = BESC_RUN;
                end
            end else if (st_reg.mode != BESC_RELEASE) begin
                st_next.mode = bus_enable_in ? BESC_RUN : BESC_STALL;
            end

            // Cycle ends at phase fall only when not stalled or released
            if (ph_if.fall && st_reg.mode == BESC_RUN && !st_reg.cycle_done) begin
                st_next.cycle_done = 1'b1;
                st_next.ready = 1'b1;
                st_next.rdata = data_in;
                st_next.mem_addr = st_reg.addr_out;
                st_next.mem_wdata = st_reg.data_out;
                st_next.mem_we = st_reg.cycle_write;
            end

            // Next cycle starts at phase rise
            if (ph_if.rise && st_reg.cycle_done && st_reg.mode == BESC_RUN) begin
                st_next.cycle_done = 1'b0;
                st_next.cycle_write = core_write;
                st_next.addr_out = core_addr;
                st_next.data_out = core_wdata;
            end

            // Outside master into internal memory
            if (st_reg.mode == BESC_RELEASE) begin
                st_next.mem_addr = addr_in;
                if (ph_if.fall && !write_strobe_n_in) begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = data_in;
                end
            end

            // Pin drivers; keepers hold addr_out while drivers are off
            st_next.addr_oe = (st_next.mode != BESC_RELEASE);
            st_next.wstrobe_oe = (st_next.mode != BESC_RELEASE);
            st_next.stall_flag = (st_next.mode == BESC_STALL);
            st_next.release_flag = (st_next.mode == BESC_RELEASE);
            st_next.wstrobe_n = !(st_next.wstrobe_oe && st_next.cycle_write &&
                                  !st_next.cycle_done && ph_if.phase);
            if (st_next.mode == BESC_RELEASE) begin
                st_next.data_oe = write_strobe_n_in && ph_if.phase;
                st_next.data_out = mem_rdata;
            end else begin
                st_next.data_oe = st_next.cycle_write && !st_next.cycle_done;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '{mode: BESC_RUN, cycle_done: 1'b1, cycle_write: 1'b0,
                        addr_out: '0, addr_oe: OE_RESET, data_out: '0, data_oe: OE_RESET,
                        wstrobe_n: STROBE_IDLE, wstrobe_oe: OE_RESET, ready: 1'b0,
                        rdata: '0, mem_addr: '0, mem_wdata: '0, mem_we: 1'b0,
                        stall_flag: 1'b0, release_flag: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign phase_two_clock_out = ph_if.phase;
    assign addr_out = st_reg.addr_out;
    assign addr_oe = st_reg.addr_oe;
    assign data_out = st_reg.data_out;
    assign data_oe = st_reg.data_oe;
    assign write_strobe_n = st_reg.wstrobe_n;
    assign write_strobe_n_oe = st_reg.wstrobe_oe;
    assign core_ready = st_reg.ready;
    assign core_rdata = st_reg.rdata;
    assign mem_addr = st_reg.mem_addr;
    assign mem_wdata = st_reg.mem_wdata;
    assign mem_we = st_reg.mem_we;
    assign stalled = st_reg.stall_flag;
    assign released = st_reg.release_flag;

    ////////////////////////////////////////////////////////////////////////////////
    a_stall_in_high: assert property (@(posedge clock) disable iff (reset)
        clock_enable && ph_if.phase && !bus_enable_in && st_reg.mode != BESC_RELEASE
        |=> st_reg.mode == BESC_STALL)
        else $error("enable low in high phase did not stall");

    a_release_in_low: assert property (@(posedge clock) disable iff (reset)
        clock_enable && !ph_if.phase && !bus_enable_in
        |=> !st_reg.addr_oe && !st_reg.wstrobe_oe)
        else $error("enable low in low phase kept address drivers on");

    a_stall_bus_driven: assert property (@(posedge clock) disable iff (reset)
        st_reg.mode == BESC_STALL |-> st_reg.addr_oe && st_reg.wstrobe_oe)
        else $error("stall released the memory bus");

    a_phase_in_stall: assert property (@(posedge clock) disable iff (reset)
        clock_enable && st_reg.mode == BESC_STALL && ph_if.phase && !slow_clock_in
        && !fast_clock_in ##1 clock_enable |-> !ph_if.phase)
        else $error("phase two frozen during stall");

    a_hold_stall: assert property (@(posedge clock) disable iff (reset)
        st_reg.mode == BESC_STALL |=> $stable(st_reg.addr_out) && !st_reg.ready)
        else $error("bus cycle changed while stalled");

    a_ready_only_run: assert property (@(posedge clock) disable iff (reset)
        st_reg.ready |-> $past(st_reg.mode) == BESC_RUN && $past(ph_if.fall))
        else $error("cycle completed outside a running fall");

    a_dma_write: assert property (@(posedge clock) disable iff (reset)
        clock_enable && st_reg.mode == BESC_RELEASE && ph_if.fall && !write_strobe_n_in
        |=> st_reg.mem_we && st_reg.mem_addr == $past(addr_in)
            && st_reg.mem_wdata == $past(data_in))
        else $error("outside master write not passed to memory");

    a_dma_read: assert property (@(posedge clock) disable iff (reset)
        clock_enable && st_reg.mode == BESC_RELEASE && !ph_if.phase && !bus_enable_in
        && write_strobe_n_in |=> !st_reg.data_oe && st_reg.data_out == $past(mem_rdata))
        else $error("outside master read data wrong");

    a_keeper_hold: assert property (@(posedge clock) disable iff (reset)
        st_reg.mode == BESC_RELEASE ##1 st_reg.mode == BESC_RELEASE
        |-> $stable(st_reg.addr_out))
        else $error("address level lost while drivers off");

    a_resume_high: assert property (@(posedge clock) disable iff (reset)
        clock_enable && st_reg.mode == BESC_STALL && ph_if.phase && bus_enable_in
        |=> st_reg.mode == BESC_RUN && !st_reg.stall_flag)
        else $error("stall not lifted in high phase with enable high");
endmodule : besc_top

/* File: inc/besc_phase_if.sv */
`timescale 1ns/100ps
interface besc_phase_if;
    logic phase;
    logic rise;
    logic fall;
    modport gen (
        output phase,
        output rise,
        output fall
    );
    modport use_side (
        input phase,
        input rise,
        input fall
    );
endinterface : besc_phase_if

/* File: inc/besc_pkg.sv */
package besc_pkg;
    // Default widths of the memory bus
    localparam int ADDR_W_DEF = 16;
    localparam int DATA_W_DEF = 8;
    // Idle level of the write strobe; reset level of the output enables and phase two
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic OE_RESET = 1'b0;
    localparam logic PHASE_RESET = 1'b0;
    // Source select encoding of the phase-two clock
    localparam logic SRC_SLOW = 1'b0;
    localparam logic SRC_FAST = 1'b1;
    // Bus ownership modes
    typedef enum logic [1:0] {
        BESC_RUN,
        BESC_STALL,
        BESC_RELEASE
    } besc_mode_t;
endpackage : besc_pkg

/* File: sim/besc_partner.sv */
`timescale 1ns/100ps
module besc_partner (
    input wire logic clock,
    input wire logic phase,
    input wire logic ready_req,
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0] dma_data,
    input wire logic [7:0] ext_rdata,
    output logic bus_enable_in,
    output logic [15:0] drv_addr,
    output logic [7:0] drv_data,
    output logic drv_strobe_n
);
    logic dma_on;
    initial begin
        dma_on = 1'b0;
        bus_enable_in = 1'b1;
        drv_addr = 16'h0000;
        drv_data = 8'h00;
        drv_strobe_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Half a cycle behind phase two; a transfer starts only in a low phase
    always @(negedge clock) begin
        dma_on <= dma_req && (dma_on || !phase);
        if (dma_req && (dma_on || !phase)) begin
            bus_enable_in <= 1'b0;
            drv_addr <= dma_addr;
            drv_data <= dma_data;
            drv_strobe_n <= !dma_write;
        end else begin
            bus_enable_in <= !phase || ready_req;
            drv_addr <= ~drv_addr;
            drv_data <= ext_rdata;
            drv_strobe_n <= ~drv_strobe_n;
        end
    end
endmodule : besc_partner

/* File: sim/tb_bus_enable_stall_control.sv */
`timescale 1ns/100ps
module tb_bus_enable_stall_control;
    import besc_pkg::*;
    logic clock, reset = 1'b1, slow_src = 1'b0, fast_src = 1'b0, src_sel = 1'b0;
    logic core_write = 1'b0, ready_req = 1'b1, dma_req = 1'b0, dma_write = 1'b0;
    logic [15:0] core_addr = 16'h0000, dma_addr = 16'h0000, addr_in, addr_out;
    logic [15:0] mem_addr, held, drv_addr;
    logic [7:0] core_wdata = 8'h00, dma_data = 8'h00, ext_rdata = 8'h00;
    logic [7:0] data_in, data_out, core_rdata, mem_wdata, mem_rdata, drv_data;
    logic phase, addr_oe, data_oe, strobe_n, strobe_oe, drv_strobe_n, strobe_in;
    logic core_ready, mem_we, stalled, released, bus_enable_in;
    logic clock_en = 1'b1, stretch = 1'b0;
    int failures = 0, comparisons = 0, cycles = 0, n;
    assign addr_in = addr_oe ? addr_out : drv_addr;
    assign data_in = data_oe ? data_out : drv_data;
    assign strobe_in = strobe_oe ? strobe_n : drv_strobe_n;
    assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
    besc_top uut (.clock(clock), .reset(reset), .clock_enable(clock_en),
        .slow_clock_in(slow_src), .fast_clock_in(fast_src),
        .phase_clock_source_select(src_sel), .bus_enable_in(bus_enable_in),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_write(core_write),
        .addr_in(addr_in), .data_in(data_in), .write_strobe_n_in(strobe_in),
        .mem_rdata(mem_rdata), .phase_two_clock_out(phase), .addr_out(addr_out),
        .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe),
        .write_strobe_n(strobe_n), .write_strobe_n_oe(strobe_oe),
        .core_ready(core_ready), .core_rdata(core_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .stalled(stalled), .released(released));
    besc_partner far_end (.clock(clock), .phase(phase), .ready_req(ready_req),
        .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr),
        .dma_data(dma_data), .ext_rdata(ext_rdata), .bus_enable_in(bus_enable_in),
        .drv_addr(drv_addr), .drv_data(drv_data), .drv_strobe_n(drv_strobe_n));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(negedge clock) begin
        cycles <= cycles + 1;
        slow_src <= cycles[2];
        if (!stretch) begin
            fast_src <= cycles[1];
        end
    end
    always @(posedge clock) begin
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wait_ready();
        @(negedge clock);
        for (n = 0; n < 60 && core_ready !== 1'b1; n++) @(negedge clock);
    endtask : wait_ready
    ////////////////////////////////////////////////////////////////////////
    task automatic phase_source();
        for (int s = 0; s < 2; s++) begin
            src_sel = s[0];
            repeat (2) @(negedge clock);
            repeat (12) begin
                @(negedge clock);
                check_bit(phase, src_sel ? fast_src : slow_src);
            end
        end
    endtask : phase_source
    task automatic proc_cycles();
        core_addr = 16'h8a31;
        core_wdata = 8'h6c;
        core_write = 1'b1;
        for (n = 0; n < 60 && strobe_n !== 1'b0; n++) @(negedge clock);
        check_bit(strobe_n, 1'b0);
        check_bit(data_oe, 1'b1);
        check_word(addr_out, core_addr);
        check_word({8'h00, data_out}, {8'h00, core_wdata});
        wait_ready();
        check_bit(mem_we, 1'b1);
        check_word({8'h00, mem_wdata}, {8'h00, core_wdata});
        core_write = 1'b0;
        ext_rdata <= 8'hc3;
        wait_ready();
        wait_ready();
        check_word({8'h00, core_rdata}, 16'h00c3);
    endtask : proc_cycles
    task automatic stall_cycles();
        int toggles;
        logic p;
        wait_ready();
        ready_req <= 1'b0;
        for (n = 0; n < 20 && stalled !== 1'b1; n++) @(negedge clock);
        check_bit(stalled, 1'b1);
        held = addr_out;
        toggles = 0;
        p = phase;
        repeat (10) begin
            @(negedge clock);
            if (phase !== p) toggles++;
            p = phase;
            check_bit(core_ready, 1'b0);
            check_bit(addr_oe, 1'b1);
            check_bit(strobe_oe, 1'b1);
            check_word(addr_out, held);
        end
        check_word(toggles[15:0], 16'h0005);
        ready_req <= 1'b1;
        wait_ready();
        check_bit(core_ready, 1'b1);
        check_bit(stalled, 1'b0);
    endtask : stall_cycles
    task automatic stretch_cycles();
        logic p;
        src_sel = 1'b1;
        wait_ready();
        stretch <= 1'b1;
        @(negedge clock);
        @(negedge clock);
        p = phase;
        repeat (12) begin
            @(negedge clock);
            check_bit(phase, p);
            check_bit(core_ready, 1'b0);
        end
        stretch <= 1'b0;
        wait_ready();
        check_bit(core_ready, 1'b1);
    endtask : stretch_cycles
    task automatic freeze_cycles();
        logic p;
        wait_ready();
        clock_en = 1'b0;
        p = phase;
        held = addr_out;
        repeat (8) begin
            @(negedge clock);
            check_bit(phase, p);
            check_word(addr_out, held);
            check_bit(core_ready, 1'b0);
        end
        clock_en = 1'b1;
        wait_ready();
        check_bit(core_ready, 1'b1);
    endtask : freeze_cycles
    task automatic dma_cycles();
        dma_addr <= 16'h01a7;
        dma_data <= 8'h3e;
        dma_write <= 1'b1;
        dma_req <= 1'b1;
        for (n = 0; n < 20 && released !== 1'b1; n++) @(negedge clock);
        check_bit(released, 1'b1);
        check_bit(addr_oe, 1'b0);
        check_bit(strobe_oe, 1'b0);
        held = addr_out;
        @(negedge clock);
        for (n = 0; n < 20 && mem_we !== 1'b1; n++) @(negedge clock);
        check_bit(mem_we, 1'b1);
        check_word(mem_addr, dma_addr);
        check_word({8'h00, mem_wdata}, {8'h00, dma_data});
        check_word(addr_out, held);
        dma_write <= 1'b0;
        @(negedge clock);
        for (n = 0; n < 20 && data_oe !== 1'b1; n++) @(negedge clock);
        check_bit(data_oe, 1'b1);
        check_word({8'h00, data_out}, {8'h00, dma_addr[7:0] ^ 8'h5a});
        dma_req <= 1'b0;
        for (n = 0; n < 20 && released !== 1'b0; n++) @(negedge clock);
        check_bit(released, 1'b0);
    endtask : dma_cycles
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clock);
        reset = 1'b0;
        phase_source();
        proc_cycles();
        stall_cycles();
        stretch_cycles();
        freeze_cycles();
        dma_cycles();
        give_verdict();
    end
endmodule : tb_bus_enable_stall_control
